// >>> spg_glue.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] capture pulse with read low loads word
// [R2] option: read strobe rise loads separate register
// [R3] combined mode shares one holding register
// [R4] readback goes most significant byte first
// [R5] byte counter advances on pulse, clears outside read window
// [R6] count selects byte 31:24 down to 7:0
// [R7] unpack when oe low, read high, dir low
// [R8] bus driven through buffer enabled by unpack
// [R9] unpacking ignores read strobe after start
// [R10] first byte driven without any capture pulse
// [R11] three more bytes on successive pulses
// [R12] boot port latches 24 bits, three cycles
// [R13] micro port address width from size register
// [R14] writes shift bytes in, LSB first
// [R15] reset clears holding word and counter
module spg_glue (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [spg_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       capture_pulse,
    input  wire logic                       read_strobe_n,
    input  wire logic                       buffer_output_enable_n,
    input  wire logic                       bus_direction,
    input  wire logic                       addr_latch_n,
    input  wire logic [spg_pkg::BYTE_W-1:0] shared_addr_data_bus_in,
    output logic      [spg_pkg::BYTE_W-1:0] shared_addr_data_bus_out,
    output logic                            shared_addr_data_bus_oe_n,
    output logic      [spg_pkg::BYTE_W-1:0] readback_byte_out,
    input  wire logic [spg_pkg::WORD_W-1:0] periph_rd_data,
    output logic      [spg_pkg::WORD_W-1:0] periph_wr_data,
    output logic      [spg_pkg::ADDR_W-1:0] latched_addr
);
    import spg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0]        ctl_f;
    logic [BYTE_W-1:0] bus_f;
    logic [WORD_W-1:0] prd_f;
    logic              cp_f;
    logic              rd_n_f;
    logic              oe_n_f;
    logic              dir_f;
    logic              ale_n_f;

    spg_sync #(.W(5)) u_sync_ctl (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({addr_latch_n, bus_direction, buffer_output_enable_n,
                   read_strobe_n, capture_pulse}),
        .q       (ctl_f)
    );

    spg_sync #(.W(WORD_W)) u_sync_data (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (periph_rd_data),
        .q       (prd_f)
    );

    // address bytes change every cycle and would stall in the agreement
    // filter; four plain stages keep them in step with the filtered controls
    logic [4*BYTE_W-1:0] bus_pipe_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_pipe_q <= '0;
        end else begin
            bus_pipe_q <= {bus_pipe_q[3*BYTE_W-1:0], shared_addr_data_bus_in};
        end
    end
    assign bus_f = bus_pipe_q[4*BYTE_W-1 -: BYTE_W];

    assign cp_f    = ctl_f[0];
    assign rd_n_f  = ctl_f[1];
    assign oe_n_f  = ctl_f[2];
    assign dir_f   = ctl_f[3];
    assign ale_n_f = ctl_f[4];

    ////////////////////////////////////////////////////////////////////////
    // edge detection on filtered levels
    logic cp_prev_q;
    logic rd_prev_q;
    logic cp_rise;
    logic rd_rise;
    logic rd_window;
    logic wr_window;
    logic unpack_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cp_prev_q <= 1'b0;
            rd_prev_q <= 1'b1;
        end else begin
            cp_prev_q <= cp_f;
            rd_prev_q <= rd_n_f;
        end
    end

    always_comb begin
        cp_rise   = cp_f && !cp_prev_q;
        rd_rise   = rd_n_f && !rd_prev_q;
        // glue owns the bus: oe low, direction low
        rd_window = !oe_n_f && !dir_f;                             // R9
        wr_window = !oe_n_f && dir_f;
        unpack_en = rd_window && rd_n_f;                           // R7
    end

    ////////////////////////////////////////////////////////////////////////
    // apb registers
    logic [1:0]        ctrl_q;
    logic [1:0]        ctrl_d;
    logic [1:0]        size_q;
    logic [1:0]        size_d;
    logic [31:0]       prdata_d;
    logic              pready_d;
    logic              pslverr_d;
    logic              wr_acc;
    logic              sep_mode;
    logic              boot_mode;
    logic [CNT_W-1:0]  cnt_q;
    logic              drive_q;
    logic [2:0]        ale_cnt_q;
    logic [WORD_W-1:0] rdw_q;
    logic [WORD_W-1:0] rdw_d;

    always_comb begin
        wr_acc    = psel && penable && pready && pwrite;
        sep_mode  = ctrl_q[CTRL_SEP_BIT];
        boot_mode = ctrl_q[CTRL_BOOT_BIT];
        ctrl_d    = ctrl_q;
        size_d    = size_q;
        if (wr_acc && !pslverr) begin
            if (paddr == CTRL_OFF) begin
                ctrl_d = pwdata[1:0];
            end else if (paddr == SIZE_OFF) begin
                size_d = pwdata[1:0];                              // R13
            end
        end
        // answer prepared in setup so access completes at once
        pready_d  = psel && !penable;
        pslverr_d = 1'b0;
        prdata_d  = 32'h0000_0000;
        if (psel && !penable) begin
            if (paddr == CTRL_OFF) begin
                prdata_d = {30'h0, ctrl_q};
            end else if (paddr == SIZE_OFF) begin
                prdata_d = {30'h0, size_q};
            end else if (paddr == HOLD_OFF) begin
                prdata_d = periph_wr_data;
            end else if (paddr == RDWORD_OFF) begin
                prdata_d = rdw_q;
            end else if (paddr == ADDR_OFF) begin
                prdata_d = {7'h0, latched_addr};
            end else if (paddr == STAT_OFF) begin
                prdata_d = {26'h0, ale_cnt_q, drive_q, cnt_q};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            size_q  <= SIZE_RST;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            size_q  <= size_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // holding register: write packing and read capture
    logic [WORD_W-1:0] hold_q;
    logic [WORD_W-1:0] hold_d;

    always_comb begin
        hold_d = hold_q;
        rdw_d  = rdw_q;
        if (cp_rise && wr_window) begin
            // first byte lands at the top and walks down to 7:0
            hold_d = {bus_f, hold_q[WORD_W-1:BYTE_W]};             // R14
        end else if (cp_rise && !rd_n_f && !sep_mode) begin
            // repeated pulses only rewrite, last value wins
            hold_d = prd_f;                                        // R1 R3
        end
        if (sep_mode && rd_rise) begin
            rdw_d = prd_f;                                         // R2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= HOLD_RST;                                    // R15
            rdw_q  <= HOLD_RST;
        end else begin
            hold_q <= hold_d;
            rdw_q  <= rdw_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unpacking: byte counter, mux and bus drive
    logic [CNT_W-1:0]  cnt_d;
    logic              drive_d;
    logic [WORD_W-1:0] src_word;
    logic [BYTE_W-1:0] sel_byte;
    logic [BYTE_W-1:0] rb_d;
    logic              bus_oe_n_d;

    always_comb begin
        src_word = sep_mode ? rdw_q : hold_q;
        cnt_d    = cnt_q;
        if (!rd_window) begin
            cnt_d = '0;                                            // R5
        end else if (cp_rise) begin
            cnt_d = cnt_q + 2'b01;                                 // R5 R11
        end
        // once started, stays on through late pulses and read edges
        drive_d = rd_window && (drive_q || unpack_en);             // R9 R10
        case (cnt_d)                                               // R6 R4
            2'b00:   sel_byte = src_word[31:24];
            2'b01:   sel_byte = src_word[23:16];
            2'b10:   sel_byte = src_word[15:8];
            default: sel_byte = src_word[7:0];
        endcase
        rb_d       = sel_byte;
        bus_oe_n_d = !(drive_d && !dir_f);                         // R8
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q                     <= '0;                       // R15
            drive_q                   <= 1'b0;
            readback_byte_out         <= 8'h00;
            shared_addr_data_bus_out  <= 8'h00;
            shared_addr_data_bus_oe_n <= 1'b1;
        end else begin
            cnt_q                     <= cnt_d;
            drive_q                   <= drive_d;
            readback_byte_out         <= rb_d;
            shared_addr_data_bus_out  <= rb_d;
            shared_addr_data_bus_oe_n <= bus_oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address latch
    logic [2:0]        ale_cnt_d;
    logic [2:0]        ale_lim;
    logic [ADDR_W-1:0] addr_d;
    logic [WORD_W-1:0] wr_data_d;

    always_comb begin
        // boot port always three bytes; micro port by size code
        if (boot_mode) begin
            ale_lim = BOOT_CYCLES;                                 // R12
        end else begin
            ale_lim = {1'b0, size_q} + 3'h1;                       // R13
        end
        ale_cnt_d = ale_n_f ? 3'h0 : ale_cnt_q;
        addr_d    = latched_addr;
        if (!ale_n_f && ale_cnt_q < ale_lim) begin
            ale_cnt_d = ale_cnt_q + 3'h1;
            case (ale_cnt_q[1:0])
                2'b00:   addr_d[7:0]   = bus_f;
                2'b01:   addr_d[15:8]  = bus_f;
                2'b10:   addr_d[23:16] = bus_f;
                default: addr_d[24]    = bus_f[0];
            endcase
        end
        wr_data_d = hold_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_cnt_q      <= 3'h0;
            latched_addr   <= '0;
            periph_wr_data <= HOLD_RST;
        end else begin
            ale_cnt_q      <= ale_cnt_d;
            latched_addr   <= addr_d;
            periph_wr_data <= wr_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_cnt_clear;
        @(posedge pclk) disable iff (!presetn)
        !rd_window |=> cnt_q == 2'b00;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)                     // R5
        else $error("byte counter not cleared");

    property p_cnt_step;
        @(posedge pclk) disable iff (!presetn)
        rd_window && cp_rise |=> cnt_q == $past(cnt_q) + 2'b01;
    endproperty
    a_cnt_step: assert property (p_cnt_step)                       // R11
        else $error("byte counter did not advance");

    property p_first_byte;
        @(posedge pclk) disable iff (!presetn)
        unpack_en && !drive_q && !cp_rise |=> !shared_addr_data_bus_oe_n
            && readback_byte_out == $past(src_word[31:24]);
    endproperty
    a_first_byte: assert property (p_first_byte)                   // R10
        else $error("first byte not presented");

    property p_last_byte;
        @(posedge pclk) disable iff (!presetn)
        rd_window && cp_rise && cnt_q == 2'b10 |=>
            readback_byte_out == $past(src_word[7:0]);
    endproperty
    a_last_byte: assert property (p_last_byte)                     // R6
        else $error("wrong byte for count three");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        cp_rise && !rd_n_f && !wr_window && !sep_mode |=>
            hold_q == $past(prd_f);
    endproperty
    a_capture: assert property (p_capture)                         // R1
        else $error("read word not captured");

    property p_sep_capture;
        @(posedge pclk) disable iff (!presetn)
        sep_mode && rd_rise |=> rdw_q == $past(prd_f);
    endproperty
    a_sep_capture: assert property (p_sep_capture)                 // R2
        else $error("separate read word not captured");

    property p_write_shift;
        @(posedge pclk) disable iff (!presetn)
        cp_rise && wr_window |=> hold_q[31:24] == $past(bus_f)
            && hold_q[23:0] == $past(hold_q[31:8]);
    endproperty
    a_write_shift: assert property (p_write_shift)                 // R14
        else $error("write byte not shifted in");

    property p_no_drive;
        @(posedge pclk) disable iff (!presetn)
        !rd_window |=> shared_addr_data_bus_oe_n;
    endproperty
    a_no_drive: assert property (p_no_drive)                       // R8
        else $error("bus driven outside read window");

    property p_boot_addr;
        @(posedge pclk) disable iff (!presetn)
        boot_mode && !ale_n_f && ale_cnt_q == 3'h3 |=>
            ale_cnt_q == 3'h3 && $stable(latched_addr);
    endproperty
    a_boot_addr: assert property (p_boot_addr)                     // R12
        else $error("boot address latched past three bytes");

    c_read4: cover property (@(posedge pclk) disable iff (!presetn)
        rd_window && cp_rise && cnt_q == 2'b11);
    c_write: cover property (@(posedge pclk) disable iff (!presetn)
        cp_rise && wr_window);
    c_addr25: cover property (@(posedge pclk) disable iff (!presetn)
        !ale_n_f && ale_cnt_q == 3'h3 && !boot_mode);
    c_sep: cover property (@(posedge pclk) disable iff (!presetn)
        sep_mode && rd_rise);
endmodule

// >>> spg_pkg.sv
`timescale 1ns/1ps
package spg_pkg;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned WORD_W        = 32;
    localparam int unsigned ADDR_W        = 25;
    localparam int unsigned CNT_W         = 2;
    localparam int unsigned APB_AW        = 8;
    localparam int unsigned SYNC_STAGES   = 3;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFF      = 8'h00;
    localparam logic [7:0]  SIZE_OFF      = 8'h04;
    localparam logic [7:0]  HOLD_OFF      = 8'h08;
    localparam logic [7:0]  RDWORD_OFF    = 8'h0c;
    localparam logic [7:0]  ADDR_OFF      = 8'h10;
    localparam logic [7:0]  STAT_OFF      = 8'h14;
    // control fields
    localparam int unsigned CTRL_SEP_BIT  = 0;
    localparam int unsigned CTRL_BOOT_BIT = 1;
    localparam logic [1:0]  CTRL_RST      = 2'h0;
    localparam logic [1:0]  SIZE_RST      = 2'h3;
    // byte cycles to latch an address
    localparam logic [2:0]  BOOT_CYCLES   = 3'h3;
    localparam logic [WORD_W-1:0] HOLD_RST = 32'h0000_0000;
    // address size code: 0=8 1=16 2=24 3=25 bits
    typedef enum logic [1:0] {
        SZ_8  = 2'b00,
        SZ_16 = 2'b01,
        SZ_24 = 2'b10,
        SZ_25 = 2'b11
    } spg_size_t;
endpackage

module spg_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import spg_pkg::*;
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_d;

    // a bit only moves once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                q_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : q[g];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= q_d;
        end
    end
endmodule

// >>> spg_far_model.sv
`timescale 1ns/1ps
// peripheral word source plus the shared byte wire seen by the glue
module spg_far_model
    import spg_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              read_strobe_n,
    input  wire logic [WORD_W-1:0] word,
    output logic      [WORD_W-1:0] periph_rd_data,
    input  wire logic [BYTE_W-1:0] glue_byte,
    input  wire logic              glue_oe_n,
    input  wire logic              proc_en,
    input  wire logic [BYTE_W-1:0] proc_byte,
    output logic      [BYTE_W-1:0] bus
);
    logic [3:0]        idle_q;
    logic [BYTE_W-1:0] last_q;

    // data hold runs out after the strobe, then the lines show junk
    always_ff @(posedge pclk) begin
        if (!read_strobe_n) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hf) begin
            idle_q <= idle_q + 4'h1;
        end
        last_q <= bus;
    end

    assign periph_rd_data = (idle_q < 4'h8) ? word : ~word;
    // undriven wire floats: inverse of the last level, not a stale copy
    assign bus = !glue_oe_n ? glue_byte : proc_en ? proc_byte : ~last_q;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import spg_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              cp, rs_n, oe_n, dir, ale_n, err, proc_en, bus_oe_n;
    logic [7:0]        proc_byte, bus, bus_out, rb;
    logic [31:0]       word, wr_data;
    logic [24:0]       laddr;
    int                error_cnt, checks_done;
    logic [31:0]       word_p;

    spg_glue dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pulse(cp), .read_strobe_n(rs_n),
        .buffer_output_enable_n(oe_n), .bus_direction(dir),
        .addr_latch_n(ale_n), .shared_addr_data_bus_in(bus),
        .shared_addr_data_bus_out(bus_out),
        .shared_addr_data_bus_oe_n(bus_oe_n), .readback_byte_out(rb),
        .periph_rd_data(word_p), .periph_wr_data(wr_data),
        .latched_addr(laddr));
    spg_far_model far (.pclk(pclk), .read_strobe_n(rs_n), .word(word),
        .periph_rd_data(word_p), .glue_byte(bus_out), .glue_oe_n(bus_oe_n),
        .proc_en(proc_en), .proc_byte(proc_byte), .bus(bus));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic pins(input logic o, input logic d, input logic r);
        @(posedge pclk);
        oe_n <= o; dir <= d; rs_n <= r;
        repeat (8) @(posedge pclk);
    endtask

    // pulse wide and spaced well beyond the synchroniser delay
    task automatic pulse();
        @(posedge pclk);
        cp <= 1'b1;
        repeat (5) @(posedge pclk);
        cp <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    task automatic ale_seq(input int nb);
        int i;
        @(posedge pclk);
        ale_n <= 1'b0; proc_en <= 1'b1;
        for (i = 0; i < nb; i++) begin
            proc_byte <= 8'h5a + 8'h11 * i[7:0];
            @(posedge pclk);
        end
        ale_n <= 1'b1; proc_en <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial begin
        #3_000_000;
        error_cnt++;
        results();
    end

    initial begin
        int i;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; cp = 1'b0; rs_n = 1'b1; oe_n = 1'b1;
        dir = 1'b0; ale_n = 1'b1; proc_en = 1'b0; proc_byte = 8'h00;
        word = 32'h0; error_cnt = 0; checks_done = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk("oe_n at reset", 32'h1, {31'h0, bus_oe_n});
        chk("wr word at reset", 32'h0, wr_data);
        apb(1'b0, HOLD_OFF, 32'h0);
        chk("hold at reset", 32'h0, rd);
        apb(1'b0, SIZE_OFF, 32'h0);
        chk("size reset", {30'h0, SIZE_RST}, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");

        // processor writes four bytes, least significant first
        pins(1'b0, 1'b1, 1'b1);
        proc_en <= 1'b1;
        for (i = 0; i < 4; i++) begin
            proc_byte <= 8'h11 * (i[7:0] + 8'h1);
            pulse();
        end
        proc_en <= 1'b0;
        pins(1'b1, 1'b0, 1'b1);
        chk("packed word", 32'h4433_2211, wr_data);
        apb(1'b1, HOLD_OFF, 32'hffff_ffff);
        apb(1'b0, HOLD_OFF, 32'h0);
        chk("hold ro", 32'h4433_2211, rd);
        $display("test write pack done");

        // read: two captures, the later word must be held
        word <= 32'h0bad_f00d;
        pins(1'b1, 1'b0, 1'b0);
        pulse();
        word <= 32'ha1b2_c3d4;
        pulse();
        pins(1'b0, 1'b0, 1'b1);
        chk("oe_n drives", 32'h0, {31'h0, bus_oe_n});
        for (i = 0; i < 5; i++) begin
            chk("readback", {24'h0, word[31 - 8 * (i % 4) -: 8]},
                {24'h0, rb});
            chk("bus byte", {24'h0, word[31 - 8 * (i % 4) -: 8]},
                {24'h0, bus});
            pulse();
        end
        pins(1'b1, 1'b0, 1'b1);
        chk("oe_n released", 32'h1, {31'h0, bus_oe_n});
        apb(1'b0, HOLD_OFF, 32'h0);
        chk("shared hold", 32'ha1b2_c3d4, rd);
        pins(1'b0, 1'b0, 1'b1);
        chk("restart byte", {24'h0, word[31:24]}, {24'h0, rb});
        pins(1'b0, 1'b1, 1'b1);
        chk("dir ends window", 32'h1, {31'h0, bus_oe_n});
        $display("test read unpack done");

        // separate mode: strobe rise captures, pulses not used
        apb(1'b1, CTRL_OFF, 32'h1);
        word <= 32'h1357_9bdf;
        pins(1'b1, 1'b0, 1'b0);
        pins(1'b1, 1'b0, 1'b1);
        apb(1'b0, RDWORD_OFF, 32'h0);
        chk("separate read word", 32'h1357_9bdf, rd);
        apb(1'b0, HOLD_OFF, 32'h0);
        chk("hold untouched", 32'ha1b2_c3d4, rd);
        $display("test separate capture done");

        // address latch: size codes, then boot port
        apb(1'b1, CTRL_OFF, 32'h0);
        apb(1'b1, SIZE_OFF, {30'h0, SZ_8});
        ale_seq(4);
        chk("addr 8 bit", 32'h5a, {7'h0, laddr});
        apb(1'b1, SIZE_OFF, {30'h0, SZ_25});
        ale_seq(4);
        chk("addr 25 bit", 32'h017c_6b5a, {7'h0, laddr});
        apb(1'b0, ADDR_OFF, 32'h0);
        chk("addr reg", 32'h017c_6b5a, rd);
        apb(1'b1, SIZE_OFF, {30'h0, SZ_16});
        ale_seq(4);
        chk("addr 16 bit", 32'h6b5a, {16'h0, laddr[15:0]});
        apb(1'b1, CTRL_OFF, 32'h2);
        ale_seq(4);
        chk("boot addr", 32'h7c6b5a, {8'h0, laddr[23:0]});
        $display("test address latch done");
        results();
    end
endmodule
